// file: bench/sord_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module sord_ctrl_model (
    // clock
    input wire logic core_clk,
    // select word and operand toward the slice
    output var sord_pkg::sord_opword_t opword,
    output var logic carry_in,
    output var logic counter_address_override,
    output var logic [3:0] data_in_port
);
    import sord_pkg::*;
    // start on an output-only form so nothing is written before the first op
    initial
    begin
        opword = '{SORD_FN_A_ONLY, SORD_ROUTE_BANK_OUT, 3'h0};
        carry_in = 1'b0;
        counter_address_override = 1'b0;
        data_in_port = 4'h0;
    end
    // one microword per cycle, launched on the falling edge; carry picks copy or step
    task op(input logic [3:0] f, input logic [1:0] r, input logic [2:0] s,
            input logic c, input logic [3:0] d, input logic o);
        @(negedge core_clk);
        opword = '{f, r, s};
        carry_in = c;
        data_in_port = d;
        counter_address_override = o;
    endtask : op
    // subtraction needs carry high into the low-order slice
    task sub(input logic [3:0] f, input logic [2:0] s, input logic [3:0] d);
        op(f, SORD_ROUTE_PORT, s, 1'b1, d, 1'b0);
    endtask : sub
endmodule : sord_ctrl_model
`default_nettype wire

// file: bench/sord_slice_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module sord_slice_asserts #(
    parameter int WIDTH = sord_pkg::SORD_WIDTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // controller side
    input wire sord_pkg::sord_opword_t opword,
    input wire logic carry_in,
    input wire logic counter_address_override,
    // data side
    input wire logic [WIDTH-1:0] data_in_port,
    input wire logic [WIDTH-1:0] data_out_port,
    input wire logic [WIDTH-1:0] address_out_port,
    input wire logic [WIDTH-1:0] working_reg_view,
    input wire logic [WIDTH-1:0] extended_working_reg_view
);
    import sord_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // short views of the select word
    wire logic pf = opword.route == SORD_ROUTE_PORT;
    wire logic [3:0] fn = opword.function_code_field;
    wire logic [2:0] sr = opword.src_sel;
    wire logic ovr = counter_address_override;
    wire logic [WIDTH-1:0] wr = working_reg_view;
    wire logic [WIDTH-1:0] xw = extended_working_reg_view;
    wire logic [WIDTH-1:0] dq = data_out_port;
    wire logic [WIDTH-1:0] di = data_in_port;
    // only the first two port forms take the address from the extended register
    wire logic xsel = pf && sr <= 3'h1;
    // port forms 3, 6 and 7 take B from the extended register
    wire logic xb = sr[1] && (sr[0] || sr[2]);
    sequence s_ext_pick;
        !ovr && xsel;
    endsequence
    // route 0 could rewrite the counter location, so it is kept out of the hold check
    sequence s_pc_hold;
        ovr && opword.route != SORD_ROUTE_BANK_BANK ##1 ovr;
    endsequence
    a_addr_ext: assert property (s_ext_pick |=> address_out_port == $past(xw))
        else $error("address not from extended register");
    a_addr_work: assert property (!ovr && !xsel |=> address_out_port == $past(wr))
        else $error("address not from working register");
    a_addr_pc: assert property (s_pc_hold |=> $stable(address_out_port))
        else $error("override address moved");
    a_sub_fwd: assert property (pf && sr != 3'h5 && fn == SORD_FN_A_MINUS_B
        |-> dq == WIDTH'(di + ~(xb ? xw : wr) + carry_in))
        else $error("input minus working wrong");
    a_sub_rev: assert property (pf && sr != 3'h5 && fn == SORD_FN_B_MINUS_A
        |-> dq == WIDTH'(~di + (xb ? xw : wr) + carry_in))
        else $error("reverse difference wrong");
    a_const_fill: assert property (fn == SORD_FN_CONST |-> dq == (carry_in ? '0 : '1))
        else $error("clear or preset value wrong");
    a_work_load: assert property (pf && sr == 3'h1 |=> wr == $past(dq))
        else $error("working register not loaded");
    a_one_dest: assert property (pf && sr == 3'h0 |=> $stable(wr) && $stable(xw))
        else $error("output form touched a register");
    a_ext_load: assert property (pf && sr == 3'h4 |=> xw == $past(dq))
        else $error("extended register not loaded");
    a_copy_inc: assert property (pf && fn == SORD_FN_A_ONLY |-> dq == WIDTH'(di + carry_in))
        else $error("copy or increment wrong");
endmodule : sord_slice_asserts
bind sord_slice sord_slice_asserts #(.WIDTH(WIDTH)) u_chk (
    .core_clk(core_clk),
    .resetn(resetn),
    .opword(opword),
    .carry_in(carry_in),
    .counter_address_override(counter_address_override),
    .data_in_port(data_in_port),
    .data_out_port(data_out_port),
    .address_out_port(address_out_port),
    .working_reg_view(working_reg_view),
    .extended_working_reg_view(extended_working_reg_view)
);
`default_nettype wire

// file: bench/tb_sord_slice.sv
`timescale 1ns/1ns
`default_nettype none
module tb_sord_slice;
    import sord_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    sord_opword_t opword;
    logic carry_in, counter_address_override, carry_out;
    logic [3:0] din, dq, addr, wr, xw;
    int mismatches = 0;
    int checks_done = 0;
    always #50 core_clk = ~core_clk;
    sord_ctrl_model ctl (.core_clk(core_clk), .opword(opword), .carry_in(carry_in),
        .counter_address_override(counter_address_override), .data_in_port(din));
    sord_slice dut (.core_clk(core_clk), .resetn(resetn), .opword(opword),
        .carry_in(carry_in), .counter_address_override(counter_address_override),
        .data_in_port(din), .data_out_port(dq), .address_out_port(addr),
        .working_reg_view(wr), .extended_working_reg_view(xw), .carry_out(carry_out));
    task chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // one op, then let the combinational result settle
    task go(input logic [3:0] f, input logic [1:0] r, input logic [2:0] s,
            input logic c, input logic [3:0] d);
        ctl.op(f, r, s, c, d, 1'b0);
        #10;
    endtask : go
    // output-only form: writes nothing, so registers show the previous op
    task idle;
        go(SORD_FN_A_ONLY, SORD_ROUTE_BANK_OUT, 3'h0, 1'b0, 4'h0);
    endtask : idle
    // reference of the function set, all mod 16
    function automatic logic [3:0] fx(input logic [3:0] f, a, b, input logic c);
        case (f)
            4'h0: return c ? 4'h0 : 4'hF;
            4'h1: return b + ~a + c;
            4'h2: return a + ~b + c;
            4'h3: return a + b + c;
            4'h4: return b + c;
            4'h5: return ~b + c;
            4'h6: return a + c;
            4'h7: return ~a + c;
            4'h8: return a ^ b;
            4'h9: return ~(a ^ b);
            4'hA: return a & b;
            4'hB: return a | b;
            4'hC: return ~(a & b);
            4'hD: return ~(a | b);
            4'hE: return a & ~b;
            default: return a;
        endcase
    endfunction : fx
    task t_transfer;
        go(SORD_FN_CONST, SORD_ROUTE_PORT, SORD_SRC_PW_WORK, 1'b0, 4'h0);
        idle;
        chk("preset", 4'hF, wr);
        go(SORD_FN_CONST, SORD_ROUTE_PORT, SORD_SRC_PW_WORK, 1'b1, 4'h0);
        idle;
        chk("clear", 4'h0, wr);
        go(SORD_FN_A_ONLY, SORD_ROUTE_PORT, SORD_SRC_PW_WORK, 1'b1, 4'h4);
        go(SORD_FN_NOT_A, SORD_ROUTE_PORT, SORD_SRC_PW_EXT, 1'b0, 4'h3);
        chk("increment", 4'h5, wr);
        go(SORD_FN_NOT_A, SORD_ROUTE_PORT, SORD_SRC_PX_EXT, 1'b1, 4'h3);
        chk("ones", 4'hC, xw);
        idle;
        chk("twos", 4'hD, xw);
        $display("transfer test done");
    endtask : t_transfer
    task t_arith;
        ctl.sub(SORD_FN_A_MINUS_B, SORD_SRC_PW_OUT, 4'h7);
        #10;
        chk("in minus wr", 4'h2, dq);
        chk("carry fwd", 4'h1, {3'h0, carry_out});
        ctl.sub(SORD_FN_B_MINUS_A, SORD_SRC_PW_OUT, 4'h7);
        #10;
        chk("wr minus in", 4'hE, dq);
        chk("carry rev", 4'h0, {3'h0, carry_out});
        go(SORD_FN_A_PLUS_B, SORD_ROUTE_PORT, SORD_SRC_PW_WORK, 1'b0, 4'h3);
        chk("wr kept", 4'h5, wr);
        go(SORD_FN_A_PLUS_B, SORD_ROUTE_PORT, SORD_SRC_PX_WORK, 1'b0, 4'h1);
        chk("in plus wr", 4'h8, wr);
        idle;
        chk("in plus xw", 4'hE, wr);
        go(SORD_FN_A_PLUS_B, SORD_ROUTE_PORT, SORD_SRC_PP_OUT, 1'b1, 4'h3);
        chk("in plus in", 4'h7, dq);
        go(SORD_FN_A_PLUS_B, SORD_ROUTE_PORT, SORD_SRC_PX_OUT, 1'b0, 4'h1);
        chk("in plus xw out", 4'hE, dq);
        for (int f = 0; f < 16; f++)
        begin
            go(4'(f), SORD_ROUTE_PORT, SORD_SRC_PW_OUT_ALT, f[0], 4'h6);
            chk("function", fx(4'(f), 4'h6, 4'hE, f[0]), dq);
        end
        $display("arith test done");
    endtask : t_arith
    task t_bank;
        for (int s = 0; s < 8; s++)
        begin
            go(SORD_FN_A_ONLY, SORD_ROUTE_PORT, SORD_SRC_PW_WORK, 1'b0, 4'(s + 1));
            go(SORD_FN_B_ONLY, SORD_ROUTE_BANK_BANK, 3'(s), 1'b0, 4'h0);
        end
        for (int s = 0; s < 8; s++)
        begin
            go(SORD_FN_A_ONLY, SORD_ROUTE_BANK_OUT, 3'(s), 1'b0, 4'h0);
            chk("bank word", 4'(s + 1), dq);
        end
        go(SORD_FN_A_ONLY, SORD_ROUTE_BANK_WORK, 3'h3, 1'b1, 4'h0);
        idle;
        chk("bank to wr", 4'h5, wr);
        repeat (2) ctl.op(SORD_FN_A_ONLY, SORD_ROUTE_BANK_OUT, 3'h0, 1'b0, 4'h0, 1'b1);
        #10;
        chk("override", 4'h8, addr);
        go(SORD_FN_A_ONLY, SORD_ROUTE_PORT, SORD_SRC_PW_OUT, 1'b0, 4'h0);
        idle;
        chk("addr ext", 4'hD, addr);
        idle;
        chk("addr work", 4'h5, addr);
        $display("bank test done");
    endtask : t_bank
    initial
    begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        summarize();
    end
    initial
    begin
        repeat (8) @(negedge core_clk);
        chk("reset wr", 4'h0, wr);
        chk("reset addr", 4'h0, addr);
        resetn = 1'b1;
        t_transfer();
        t_arith();
        t_bank();
        summarize();
    end
endmodule : tb_sord_slice
`default_nettype wire

// file: rtl/sord_alu.sv
`timescale 1ns/1ns
`default_nettype none

module sord_alu #(
    parameter int WIDTH = sord_pkg::SORD_WIDTH
) (
    // operands
    input wire logic [3:0] fn,
    input wire logic [WIDTH-1:0] a,
    input wire logic [WIDTH-1:0] b,
    input wire logic carry_in,
    // result
    output logic [WIDTH-1:0] result,
    output logic carry_out
);
    import sord_pkg::*;

    // ripple add of two words and the carry, carry in the top bit
    function automatic logic [WIDTH:0] sord_add(input logic [WIDTH-1:0] x,
                                                input logic [WIDTH-1:0] y,
                                                input logic c);
        sord_add = {1'b0, x} + {1'b0, y} + {{WIDTH{1'b0}}, c};
    endfunction : sord_add

    logic [WIDTH:0] sum; // arithmetic result with carry
    logic [WIDTH-1:0] logic_out; // boolean result
    logic [WIDTH-1:0] zeros; // all-low word
    assign zeros = '0;

    // arithmetic half: subtraction is add of the complement plus carry
    always_comb
    begin
        unique case (fn)
            SORD_FN_CONST: sum = {1'b0, carry_in ? zeros : ~zeros};
            SORD_FN_B_MINUS_A: sum = sord_add(b, ~a, carry_in);
            SORD_FN_A_MINUS_B: sum = sord_add(a, ~b, carry_in);
            SORD_FN_A_PLUS_B: sum = sord_add(a, b, carry_in);
            SORD_FN_B_ONLY: sum = sord_add(b, zeros, carry_in);
            SORD_FN_NOT_B: sum = sord_add(~b, zeros, carry_in);
            SORD_FN_A_ONLY: sum = sord_add(a, zeros, carry_in);
            SORD_FN_NOT_A: sum = sord_add(~a, zeros, carry_in);
            default: sum = {1'b0, zeros};
        endcase
    end

    // boolean half ignores the carry
    always_comb
    begin
        unique case (fn)
            SORD_FN_XOR: logic_out = a ^ b;
            SORD_FN_XNOR: logic_out = ~(a ^ b);
            SORD_FN_AND: logic_out = a & b;
            SORD_FN_OR: logic_out = a | b;
            SORD_FN_NAND: logic_out = ~(a & b);
            SORD_FN_NOR: logic_out = ~(a | b);
            SORD_FN_A_AND_NOT_B: logic_out = a & ~b;
            SORD_FN_PASS_A: logic_out = a;
            default: logic_out = zeros;
        endcase
    end

    // top bit of the code splits the sixteen functions eight and eight
    assign result = fn[3] ? logic_out : sum[WIDTH-1:0];
    assign carry_out = fn[3] ? 1'b0 : sum[WIDTH];

endmodule : sord_alu

`default_nettype wire

// file: rtl/sord_pkg.sv
package sord_pkg;

    // slice geometry
    localparam int SORD_WIDTH = 4;
    localparam int SORD_BANK_DEPTH = 8;
    localparam logic [2:0] SORD_PC_LOC = 3'h7;

    // routing field codes
    localparam logic [1:0] SORD_ROUTE_BANK_BANK = 2'h0;
    localparam logic [1:0] SORD_ROUTE_BANK_WORK = 2'h1;
    localparam logic [1:0] SORD_ROUTE_BANK_OUT = 2'h2;
    localparam logic [1:0] SORD_ROUTE_PORT = 2'h3;

    // source-select codes used when the routing field picks the port forms
    localparam logic [2:0] SORD_SRC_PW_OUT = 3'h0;
    localparam logic [2:0] SORD_SRC_PW_WORK = 3'h1;
    localparam logic [2:0] SORD_SRC_PW_OUT_ALT = 3'h2;
    localparam logic [2:0] SORD_SRC_PX_WORK = 3'h3;
    localparam logic [2:0] SORD_SRC_PW_EXT = 3'h4;
    localparam logic [2:0] SORD_SRC_PP_OUT = 3'h5;
    localparam logic [2:0] SORD_SRC_PX_EXT = 3'h6;
    localparam logic [2:0] SORD_SRC_PX_OUT = 3'h7;

    // function codes: 0..7 arithmetic, 8..F boolean
    localparam logic [3:0] SORD_FN_CONST = 4'h0;
    localparam logic [3:0] SORD_FN_B_MINUS_A = 4'h1;
    localparam logic [3:0] SORD_FN_A_MINUS_B = 4'h2;
    localparam logic [3:0] SORD_FN_A_PLUS_B = 4'h3;
    localparam logic [3:0] SORD_FN_B_ONLY = 4'h4;
    localparam logic [3:0] SORD_FN_NOT_B = 4'h5;
    localparam logic [3:0] SORD_FN_A_ONLY = 4'h6;
    localparam logic [3:0] SORD_FN_NOT_A = 4'h7;
    localparam logic [3:0] SORD_FN_XOR = 4'h8;
    localparam logic [3:0] SORD_FN_XNOR = 4'h9;
    localparam logic [3:0] SORD_FN_AND = 4'hA;
    localparam logic [3:0] SORD_FN_OR = 4'hB;
    localparam logic [3:0] SORD_FN_NAND = 4'hC;
    localparam logic [3:0] SORD_FN_NOR = 4'hD;
    localparam logic [3:0] SORD_FN_A_AND_NOT_B = 4'hE;
    localparam logic [3:0] SORD_FN_PASS_A = 4'hF;

    // reset value of every storage word
    localparam logic [SORD_WIDTH-1:0] SORD_RESET_WORD = 4'h0;

    // operand B source
    typedef enum logic [1:0] {
        SORD_B_WORK,
        SORD_B_EXT,
        SORD_B_PORT
    } sord_b_src_t;

    // result destination
    typedef enum logic [1:0] {
        SORD_DST_OUT,
        SORD_DST_BANK,
        SORD_DST_WORK,
        SORD_DST_EXT
    } sord_dest_t;

    // operation-select word as driven by the controller
    typedef struct packed {
        logic [3:0] function_code_field;
        logic [1:0] route;
        logic [2:0] src_sel;
    } sord_opword_t;

    // decoded routing
    typedef struct packed {
        logic a_from_port;
        sord_b_src_t b_src;
        sord_dest_t dest;
        logic addr_from_ext;
    } sord_route_t;

endpackage : sord_pkg

// file: rtl/sord_slice.sv
`timescale 1ns/1ns
`default_nettype none

module sord_slice #(
    parameter int WIDTH = sord_pkg::SORD_WIDTH,
    parameter int BANK_DEPTH = sord_pkg::SORD_BANK_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // operation select from the controller
    input wire sord_pkg::sord_opword_t opword,
    input wire logic carry_in,
    input wire logic counter_address_override,
    // data ports
    input wire logic [WIDTH-1:0] data_in_port,
    output logic [WIDTH-1:0] data_out_port,
    output logic [WIDTH-1:0] address_out_port,
    // register views for status
    output logic [WIDTH-1:0] working_reg_view,
    output logic [WIDTH-1:0] extended_working_reg_view,
    output logic carry_out
);
    import sord_pkg::*;

    // elaboration check: source field is three bits wide
    if (BANK_DEPTH != SORD_BANK_DEPTH || WIDTH < 1)
    begin : g_bad_params
        $error("sord_slice: bank depth must be eight and width positive");
    end

    // storage: reset clears every word, so the counter location starts at zero
    logic [WIDTH-1:0] reg_bank [BANK_DEPTH]; // register bank, location 7 is the counter
    logic [WIDTH-1:0] working_reg; // working register
    logic [WIDTH-1:0] extended_working_reg; // extended working register

    // decode of routing and source fields into operand and destination choice;
    // routes 0 to 2 take A from the bank location named by the source field
    // and B from the working register, and differ only in the destination;
    // route 3 takes A from the data input and lets the source field pick
    // both B and the destination; every code decodes, so there is no default
    function automatic sord_route_t sord_decode(input logic [1:0] route,
                                                input logic [2:0] src);
        sord_route_t r;
        r.a_from_port = 1'b0;
        r.b_src = SORD_B_WORK;
        r.dest = SORD_DST_BANK;
        r.addr_from_ext = 1'b0;
        unique case (route)
            SORD_ROUTE_BANK_BANK: r.dest = SORD_DST_BANK;
            SORD_ROUTE_BANK_WORK: r.dest = SORD_DST_WORK;
            SORD_ROUTE_BANK_OUT: r.dest = SORD_DST_OUT;
            SORD_ROUTE_PORT:
            begin
                r.a_from_port = 1'b1;
                unique case (src)
                    SORD_SRC_PW_OUT:
                    begin
                        r.dest = SORD_DST_OUT;
                        r.addr_from_ext = 1'b1;
                    end
                    SORD_SRC_PW_WORK:
                    begin
                        r.dest = SORD_DST_WORK;
                        r.addr_from_ext = 1'b1;
                    end
                    SORD_SRC_PW_OUT_ALT: r.dest = SORD_DST_OUT;
                    SORD_SRC_PX_WORK:
                    begin
                        r.b_src = SORD_B_EXT;
                        r.dest = SORD_DST_WORK;
                    end
                    SORD_SRC_PW_EXT: r.dest = SORD_DST_EXT;
                    SORD_SRC_PP_OUT:
                    begin
                        r.b_src = SORD_B_PORT;
                        r.dest = SORD_DST_OUT;
                    end
                    SORD_SRC_PX_EXT:
                    begin
                        r.b_src = SORD_B_EXT;
                        r.dest = SORD_DST_EXT;
                    end
                    SORD_SRC_PX_OUT:
                    begin
                        r.b_src = SORD_B_EXT;
                        r.dest = SORD_DST_OUT;
                    end
                endcase
            end
        endcase
        sord_decode = r;
    endfunction : sord_decode

    // decoded controls
    // all of these are combinational and settle well before the next edge
    sord_route_t route_sel; // operand, destination and address choice
    logic [WIDTH-1:0] bank_word; // bank location named by the source field
    logic [WIDTH-1:0] operand_a; // ALU A input
    logic [WIDTH-1:0] operand_b; // ALU B input
    logic [WIDTH-1:0] alu_result; // ALU output
    logic alu_carry; // ALU carry out
    logic [WIDTH-1:0] next_address; // address selector output

    assign route_sel = sord_decode(opword.route, opword.src_sel);
    // the source field names the location read for A and, on route 0, the
    // location written back, so a read-modify-write takes a single cycle
    assign bank_word = reg_bank[opword.src_sel];
    assign operand_a = route_sel.a_from_port ? data_in_port : bank_word;
    // B: the data input for one port form, the extended register for the
    // forms that name it, and the working register everywhere else
    assign operand_b = (route_sel.b_src == SORD_B_PORT) ? data_in_port
                     : (route_sel.b_src == SORD_B_EXT) ? extended_working_reg
                     : working_reg;

    // the function code applies to whatever routing was picked
    sord_alu #(
        .WIDTH(WIDTH)
    ) u_alu (
        .fn(opword.function_code_field),
        .a(operand_a),
        .b(operand_b),
        .carry_in(carry_in),
        .result(alu_result),
        .carry_out(alu_carry)
    );

    // output port shows the result in every cycle, whatever the destination;
    // it cannot be a flop or a bank write would not be visible until later
    assign data_out_port = alu_result;
    // carry out stays combinational as well: slices cascade to wider words,
    // and the next slice needs this carry within the same cycle
    assign carry_out = alu_carry;

    // override wins over the decoded choice of the address selector;
    // the counter location is read straight from the bank, not through A
    assign next_address = counter_address_override ? reg_bank[SORD_PC_LOC]
                        : route_sel.addr_from_ext ? extended_working_reg
                        : working_reg;

    // bank: written only when it is the single destination; the location
    // written is the one read for A, and writing location 7 moves the
    // counter that the override puts on the address port
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < BANK_DEPTH; i++)
            begin
                reg_bank[i] <= SORD_RESET_WORD;
            end
        end
        else if (route_sel.dest == SORD_DST_BANK)
        begin
            reg_bank[opword.src_sel] <= alu_result;
        end
    end

    // working register: loaded by route 1 and by the port forms that name it;
    // it also feeds the address selector whenever no marked form is decoded and the override is low
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            working_reg <= SORD_RESET_WORD;
        end
        else if (route_sel.dest == SORD_DST_WORK)
        begin
            working_reg <= alu_result;
        end
    end

    // extended working register
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            extended_working_reg <= SORD_RESET_WORD;
        end
        else if (route_sel.dest == SORD_DST_EXT)
        begin
            extended_working_reg <= alu_result;
        end
    end

    // address port is registered, so it trails the decode by one edge;
    // the value taken is the selected register as it stood before that edge,
    // so a write and an address fetch of one register never race
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            address_out_port <= SORD_RESET_WORD;
        end
        else
        begin
            address_out_port <= next_address;
        end
    end

    // register views are wires off the flops, so they show the stored words
    assign working_reg_view = working_reg;
    assign extended_working_reg_view = extended_working_reg;

endmodule : sord_slice

`default_nettype wire
